// >>> flash_cmd_pkg.sv
// package of constants for the serial flash command block
package flash_cmd_pkg;
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OP_READ_BYTES = 8'h03;
    localparam logic [7:0] OP_FAST_READ = 8'h0B;
    localparam logic [7:0] OP_READ_SILICON_ID = 8'hAB;
    localparam logic [7:0] OP_READ_DEVICE_ID = 8'h9F;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_WRITE_BYTES = 8'h02;
    localparam logic [7:0] OP_ERASE_BULK = 8'hC7;
    localparam logic [7:0] OP_ERASE_SECTOR = 8'hD8;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_WEL_BIT = 1;
    localparam int STATUS_BP_LSB = 2;
    localparam int STATUS_BP_W = 3;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam int ADDR_W = 24;
    localparam int READ_ADDR_BYTES = 3;
    localparam int FAST_DUMMY_BYTES = 1;
    localparam int SID_DUMMY_BYTES = 3;
    localparam int DID_DUMMY_BYTES = 2;
    localparam int SYS_CLK_HZ = 20_000_000;
    localparam int STATUS_WRITE_CYCLE_TIME_US = 5_000;
    localparam int STATUS_WRITE_CYCLE_MAX_US = 15_000;
    localparam int STATUS_WRITE_CYCLES =
        int'((64'(STATUS_WRITE_CYCLE_TIME_US) * 64'(SYS_CLK_HZ)) / 64'd1_000_000);
    typedef enum logic [2:0] {
        PH_OPCODE, PH_ADDR, PH_DUMMY, PH_DATA_IN, PH_DATA_OUT, PH_IGNORE
    } phase_t;
endpackage

// >>> serial_flash_cmds.sv
// serial flash command decoder for status write, reads and identification
// Functional notes
// - opcode 0x01, MSB first, decodes as write status.
// - write status changes only the block protect bits.
// - protected sectors are read-only; program and sector erase refused there; no sector erase command is decoded here.
// - write status frame is opcode plus one byte, then chip select rises.
// - valid frame starts self-timed status write, typical 5 ms, under 15 ms.
// - busy bit held 1 during status write, cleared when done.
// - read bytes is 0x03 plus 24-bit address sampled on rising edges.
// - data driven on falling edges, MSB first; raw images LSB first.
// - read bytes advances address per byte, wraps to zero at top.
// - read bytes during a busy cycle is ignored.
// - fast read is opcode, address, one dummy byte, then data out.
// - fast read increments address, rolls over to zero, stops on deselect.
// - fast read during a busy cycle is rejected.
// - silicon ID read is 0xAB plus three dummy bytes, then 8-bit code.
// - identification code repeats while selected and clocked.
// - identification reads during a busy cycle are ignored.
// - device identification read is 0x9F plus two dummy bytes.
// - address bits above capacity are don't-care.
// - busy flag at status bit 0; status readable at any time.
// - write enable latch clears at reset, write disable, cycle completion.
// - modifying commands execute only on an exact byte boundary deselect.
module serial_flash_cmds
    import flash_cmd_pkg::*;
#(
    parameter int MEM_ADDR_W = 8,
    parameter int WRITE_CYCLES = STATUS_WRITE_CYCLES,
    parameter int DEVICE_ID_W = 16,
    parameter logic [7:0] SILICON_ID = 8'h5A,
    parameter logic [DEVICE_ID_W-1:0] DEVICE_ID = 16'h00A5,
    parameter bit HAS_DEVICE_ID = 1'b0
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic serial_clock,
    input wire logic chip_select_low,
    input wire logic serial_data_in,
    input wire logic raw_lsb_first,
    input wire logic mem_we,
    input wire logic [MEM_ADDR_W-1:0] mem_waddr,
    input wire logic [7:0] mem_wdata,
    input wire logic [MEM_ADDR_W-1:0] prog_addr,
    input wire logic prog_req,
    output logic prog_refused,
    output logic data_out,
    output logic data_out_en,
    output logic write_in_progress,
    output logic [STATUS_BP_W-1:0] block_protect
);
    import flash_cmd_pkg::*;
    // SILICON_ID and DEVICE_ID defaults are arbitrary values
    initial begin
        if (MEM_ADDR_W < 1 || MEM_ADDR_W > ADDR_W) $error("bad MEM_ADDR_W");
        if (DEVICE_ID_W < 8 || DEVICE_ID_W % 8 != 0) $error("bad DEVICE_ID_W");
        if (WRITE_CYCLES < 1) $error("bad WRITE_CYCLES");
    end

    localparam int DEPTH = 1 << MEM_ADDR_W;
    logic [7:0] mem [DEPTH];

    // ---------------- link domain (serial_clock) ----------------
    phase_t phase_reg;
    logic [7:0] shift_reg;
    logic [2:0] bit_cnt_reg;
    logic [1:0] byte_cnt_reg;
    logic [7:0] opcode_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [7:0] wdata_reg;
    logic frame_ok_reg;
    logic frame_toggle_reg;
    logic busy_l1_reg, busy_l2_reg;
    logic [7:0] tx_reg;
    logic [7:0] out_byte_reg;
    logic lsb_l1_reg, lsb_l2_reg;
    logic [STATUS_BP_W-1:0] bp_l1_reg, bp_l2_reg;
    logic wel_l1_reg, wel_l2_reg;
    logic wel_reg;
    logic lsb_now;
    logic [7:0] out_rev;
    logic [7:0] status_view;
    logic [7:0] rx_byte;
    logic [7:0] id_byte;

    function automatic logic [7:0] id_slice(input logic [1:0] idx);
        logic [DEVICE_ID_W-1:0] sh;
        sh = DEVICE_ID >> (8 * (DEVICE_ID_W / 8 - 1 - int'(idx)));
        return sh[7:0];
    endfunction

    assign rx_byte = {shift_reg[6:0], serial_data_in};
    assign status_view = {3'b000, bp_l2_reg, wel_l2_reg, busy_l2_reg};
    assign id_byte = HAS_DEVICE_ID ? id_slice(byte_cnt_reg) : SILICON_ID;
    // raw image order applies to memory data only, never to status or id bytes
    assign lsb_now = lsb_l2_reg && (opcode_reg == OP_READ_BYTES || opcode_reg == OP_FAST_READ);
    assign out_rev = {<<{out_byte_reg}};

    // opcode and status byte outlive the frame so the system side can read them
    always_ff @(posedge serial_clock or posedge rst) begin
        if (rst) begin
            opcode_reg <= 8'h00;
            wdata_reg <= 8'h00;
        end else if (!chip_select_low && bit_cnt_reg == 3'd7) begin
            if (phase_reg == PH_OPCODE) begin
                opcode_reg <= rx_byte;
            end
            if (phase_reg == PH_DATA_IN) begin
                wdata_reg <= rx_byte;
            end
        end
    end

    // status bits cross into the link domain; bits may skew by one link edge
    always_ff @(posedge serial_clock or posedge chip_select_low) begin
        if (chip_select_low) begin
            busy_l1_reg <= 1'b0;
            busy_l2_reg <= 1'b0;
            wel_l1_reg <= 1'b0;
            wel_l2_reg <= 1'b0;
            bp_l1_reg <= '0;
            bp_l2_reg <= '0;
            lsb_l1_reg <= 1'b0;
            lsb_l2_reg <= 1'b0;
        end else begin
            busy_l1_reg <= write_in_progress;
            busy_l2_reg <= busy_l1_reg;
            wel_l1_reg <= wel_reg;
            wel_l2_reg <= wel_l1_reg;
            bp_l1_reg <= block_protect;
            bp_l2_reg <= bp_l1_reg;
            lsb_l1_reg <= raw_lsb_first;
            lsb_l2_reg <= lsb_l1_reg;
        end
    end

    // frame decode; chip select high acts as the frame reset
    always_ff @(posedge serial_clock or posedge chip_select_low) begin
        if (chip_select_low) begin
            phase_reg <= PH_OPCODE;
            shift_reg <= 8'h00;
            bit_cnt_reg <= 3'd0;
            byte_cnt_reg <= 2'd0;
            addr_reg <= '0;
            frame_ok_reg <= 1'b0;
            out_byte_reg <= 8'h00;
        end else begin
            shift_reg <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 3'd1;
            frame_ok_reg <= 1'b0;
            if (bit_cnt_reg == 3'd7) begin
                byte_cnt_reg <= byte_cnt_reg + 2'd1;
                case (phase_reg)
                    PH_OPCODE: begin
                        byte_cnt_reg <= 2'd0;
                        case (rx_byte)
                            OP_WRITE_STATUS: phase_reg <= PH_DATA_IN;
                            OP_READ_BYTES, OP_FAST_READ:
                                phase_reg <= busy_l2_reg ? PH_IGNORE : PH_ADDR;
                            OP_READ_SILICON_ID, OP_READ_DEVICE_ID:
                                phase_reg <= busy_l2_reg ? PH_IGNORE : PH_DUMMY;
                            OP_READ_STATUS: begin
                                phase_reg <= PH_DATA_OUT;
                                out_byte_reg <= status_view;
                            end
                            OP_WRITE_ENABLE, OP_WRITE_DISABLE: begin
                                frame_ok_reg <= 1'b1;
                                phase_reg <= PH_IGNORE;
                            end
                            default: phase_reg <= PH_IGNORE;
                        endcase
                    end
                    PH_ADDR: begin
                        addr_reg <= {addr_reg[ADDR_W-9:0], rx_byte};
                        if (byte_cnt_reg == 2'(READ_ADDR_BYTES - 1)) begin
                            byte_cnt_reg <= 2'd0;
                            if (opcode_reg == OP_FAST_READ) begin
                                phase_reg <= PH_DUMMY;
                            end else begin
                                phase_reg <= PH_DATA_OUT;
                                out_byte_reg <= mem[rx_byte[MEM_ADDR_W-1:0] |
                                    MEM_ADDR_W'({addr_reg[15:0], 8'h00})];
                                addr_reg <= {addr_reg[15:0], rx_byte} + 24'd1;
                            end
                        end
                    end
                    PH_DUMMY: begin
                        if ((opcode_reg == OP_FAST_READ &&
                             byte_cnt_reg == 2'(FAST_DUMMY_BYTES - 1)) ||
                            (opcode_reg == OP_READ_SILICON_ID &&
                             byte_cnt_reg == 2'(SID_DUMMY_BYTES - 1)) ||
                            (opcode_reg == OP_READ_DEVICE_ID &&
                             byte_cnt_reg == 2'(DID_DUMMY_BYTES - 1))) begin
                            phase_reg <= PH_DATA_OUT;
                            byte_cnt_reg <= 2'd0;
                            if (opcode_reg == OP_FAST_READ) begin
                                out_byte_reg <= mem[addr_reg[MEM_ADDR_W-1:0]];
                                addr_reg <= addr_reg + 24'd1;
                            end else if (opcode_reg == OP_READ_DEVICE_ID) begin
                                out_byte_reg <= id_slice(2'd0);
                                byte_cnt_reg <= 2'd1;
                            end else begin
                                out_byte_reg <= SILICON_ID;
                            end
                        end
                    end
                    PH_DATA_IN: begin
                        frame_ok_reg <= 1'b1;
                        phase_reg <= PH_IGNORE;
                    end
                    PH_DATA_OUT: begin
                        case (opcode_reg)
                            OP_READ_BYTES, OP_FAST_READ: begin
                                out_byte_reg <= mem[addr_reg[MEM_ADDR_W-1:0]];
                                // narrow array wraps at capacity; upper bits unused
                                addr_reg <= addr_reg + 24'd1;
                            end
                            OP_READ_STATUS: out_byte_reg <= status_view;
                            OP_READ_DEVICE_ID: begin
                                out_byte_reg <= id_byte;
                                byte_cnt_reg <= (byte_cnt_reg == 2'(DEVICE_ID_W / 8 - 1)) ?
                                    2'd0 : byte_cnt_reg + 2'd1;
                            end
                            default: out_byte_reg <= SILICON_ID;
                        endcase
                    end
                    default: begin
                        // extra bytes break the byte-exact frame
                        frame_ok_reg <= 1'b0;
                    end
                endcase
            end
        end
    end

    // output drives on falling edges; a byte loads at bit 0 of each data byte
    always_ff @(negedge serial_clock or posedge chip_select_low) begin
        if (chip_select_low) begin
            tx_reg <= 8'h00;
        end else if (phase_reg == PH_DATA_OUT && bit_cnt_reg == 3'd0) begin
            // first bit goes straight to data_out, so only the remaining seven load here
            tx_reg <= lsb_now ? {out_rev[6:0], 1'b0} : {out_byte_reg[6:0], 1'b0};
        end else begin
            tx_reg <= {tx_reg[6:0], 1'b0};
        end
    end

    always_ff @(negedge serial_clock or posedge chip_select_low) begin
        if (chip_select_low) begin
            data_out <= 1'b0;
            data_out_en <= 1'b0;
        end else begin
            data_out_en <= (phase_reg == PH_DATA_OUT);
            data_out <= (phase_reg == PH_DATA_OUT && bit_cnt_reg == 3'd0) ?
                (lsb_now ? out_byte_reg[0] : out_byte_reg[7]) : tx_reg[7];
        end
    end

    // frame end: toggle when chip select rises on a byte-exact frame
    always_ff @(posedge chip_select_low or posedge rst) begin
        if (rst) begin
            frame_toggle_reg <= 1'b0;
        end else if (frame_ok_reg && bit_cnt_reg == 3'd0) begin
            frame_toggle_reg <= ~frame_toggle_reg;
        end
    end

    // ---------------- system domain ----------------
    logic tog_s1_reg, tog_s2_reg, tog_s3_reg;
    logic [7:0] op_s1_reg, op_s2_reg, dat_s1_reg, dat_s2_reg;
    logic [$clog2(WRITE_CYCLES+1)-1:0] timer_reg;
    logic frame_evt;
    assign frame_evt = tog_s2_reg ^ tog_s3_reg;

    // opcode and data are stable once the toggle is seen two edges later
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tog_s1_reg <= 1'b0;
            tog_s2_reg <= 1'b0;
            tog_s3_reg <= 1'b0;
            op_s1_reg <= 8'h00;
            op_s2_reg <= 8'h00;
            dat_s1_reg <= 8'h00;
            dat_s2_reg <= 8'h00;
        end else begin
            tog_s1_reg <= frame_toggle_reg;
            tog_s2_reg <= tog_s1_reg;
            tog_s3_reg <= tog_s2_reg;
            op_s1_reg <= opcode_reg;
            op_s2_reg <= op_s1_reg;
            dat_s1_reg <= wdata_reg;
            dat_s2_reg <= dat_s1_reg;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wel_reg <= STATUS_RESET[STATUS_WEL_BIT];
            write_in_progress <= STATUS_RESET[STATUS_BUSY_BIT];
            block_protect <= STATUS_RESET[STATUS_BP_LSB +: STATUS_BP_W];
            timer_reg <= '0;
        end else if (write_in_progress) begin
            timer_reg <= timer_reg - 1'b1;
            if (timer_reg == 1) begin
                write_in_progress <= 1'b0;
                wel_reg <= 1'b0;
                block_protect <= dat_s2_reg[STATUS_BP_LSB +: STATUS_BP_W];
            end
        end else if (frame_evt) begin
            case (op_s2_reg)
                OP_WRITE_ENABLE: wel_reg <= 1'b1;
                OP_WRITE_DISABLE: wel_reg <= 1'b0;
                OP_WRITE_STATUS: if (wel_reg) begin
                    write_in_progress <= 1'b1;
                    timer_reg <= ($clog2(WRITE_CYCLES+1))'(WRITE_CYCLES);
                end
                default: wel_reg <= wel_reg;
            endcase
        end
    end

    // protected upper region refuses program requests and blocks memory writes
    function automatic logic is_protected(input logic [MEM_ADDR_W-1:0] a,
                                          input logic [STATUS_BP_W-1:0] bp);
        logic [MEM_ADDR_W:0] lim;
        lim = (bp == '0) ? (MEM_ADDR_W+1)'(DEPTH) :
              (bp >= 3'd7) ? '0 : (MEM_ADDR_W+1)'(DEPTH) - ((MEM_ADDR_W+1)'(DEPTH) >> (7 - bp));
        return {1'b0, a} >= lim;
    endfunction

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prog_refused <= 1'b0;
        end else begin
            prog_refused <= prog_req && is_protected(prog_addr, block_protect);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (mem_we && !is_protected(mem_waddr, block_protect)) begin
            mem[mem_waddr] <= mem_wdata;
        end
    end
endmodule // serial_flash_cmds

// >>> serial_flash_cmds_chk.sv
// concurrent checks on the serial flash command block ports
module serial_flash_cmds_chk
    import flash_cmd_pkg::*;
#(
    parameter int WRITE_CYCLES = 20
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic chip_select_low,
    input wire logic prog_req,
    input wire logic prog_refused,
    input wire logic data_out_en,
    input wire logic write_in_progress,
    input wire logic [STATUS_BP_W-1:0] block_protect
);
    logic [31:0] busy_cnt_reg;
    logic [31:0] busy_cnt_next;

    // count of sampled busy cycles, cleared whenever idle
    assign busy_cnt_next = write_in_progress ? busy_cnt_reg + 32'h0000_0001 : 32'h0000_0000;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            busy_cnt_reg <= 32'h0000_0000;
        end else begin
            busy_cnt_reg <= busy_cnt_next;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    chk_busy_length: assert property ($fell(write_in_progress) |->
        busy_cnt_reg >= WRITE_CYCLES - 1 && busy_cnt_reg <= WRITE_CYCLES + 1)
        else $error("status write busy time off");
    chk_protect_at_end: assert property (!$fell(write_in_progress) |-> $stable(block_protect))
        else $error("protect bits moved outside completion");
    chk_busy_after_deselect: assert property ($rose(write_in_progress) |->
        chip_select_low && $past(chip_select_low, 2))
        else $error("busy rose without deselect");
    chk_out_idle_deselect: assert property (chip_select_low && $past(chip_select_low) |->
        !data_out_en)
        else $error("output enabled while deselected");
    chk_busy_no_read: assert property (write_in_progress |-> !data_out_en)
        else $error("read answered during busy");
    chk_refuse_cause: assert property (prog_refused |-> $past(prog_req) || $past(prog_req, 2))
        else $error("refusal without request");
    chk_refuse_open: assert property ((block_protect == 3'h0) && ($past(block_protect) == 3'h0)
        && ($past(block_protect, 2) == 3'h0) |-> !prog_refused)
        else $error("refusal with nothing protected");
    chk_refuse_pulse: assert property (prog_refused && !prog_req |=> !prog_refused)
        else $error("refusal longer than one cycle");
endmodule // serial_flash_cmds_chk

bind serial_flash_cmds serial_flash_cmds_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
    .sys_clk(sys_clk),
    .rst(rst),
    .chip_select_low(chip_select_low),
    .prog_req(prog_req),
    .prog_refused(prog_refused),
    .data_out_en(data_out_en),
    .write_in_progress(write_in_progress),
    .block_protect(block_protect)
);

// >>> flash_master_model.sv
// serial master model that frames commands and collects read data
module flash_master_model (
    output logic serial_clock,
    output logic chip_select_low,
    output logic serial_data_in,
    input wire logic data_out
);
    timeunit 1ns;
    timeprecision 100ps;

    // link clock stands low between frames
    // behavioural master: clock rate limits of read commands are not modelled
    initial begin
        serial_clock = 1'b0;
        chip_select_low = 1'b1;
        serial_data_in = 1'b0;
    end

    // sends the top ntx bits of tx, then clocks nrx more bits in from data_out
    task automatic xfer(input logic [47:0] tx, input int ntx, input int nrx,
                        output logic [15:0] rx);
        rx = 16'h0000;
        chip_select_low = 1'b0;
        #3;
        for (int i = 0; i < ntx + nrx; i++) begin
            // data changes while the clock is low, so the rising edge sees it settled
            serial_data_in = (i < ntx) ? tx[47-i] : ~serial_data_in;
            #3 serial_clock = 1'b1;
            if (i >= ntx) begin
                rx = {rx[14:0], data_out};
            end
            #3 serial_clock = 1'b0;
        end
        #3 chip_select_low = 1'b1;
        // released line must not keep the last value
        serial_data_in = ~serial_data_in;
    endtask
endmodule // flash_master_model

// >>> tb_serial_flash_read_and_status_cmds.sv
// self-checking bench for the serial flash command block
module tb_serial_flash_read_and_status_cmds;
    import flash_cmd_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [7:0] SID = 8'h3C; // arbitrary value
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic raw_lsb_first = 1'b0;
    logic mem_we = 1'b0;
    logic prog_req = 1'b0;
    logic [7:0] mem_waddr = 8'h00;
    logic [7:0] mem_wdata = 8'h00;
    logic [7:0] prog_addr = 8'h00;
    logic serial_clock, chip_select_low, serial_data_in, data_out, data_out_en;
    logic write_in_progress, prog_refused;
    logic [2:0] block_protect;
    logic [15:0] rx;
    logic seen;
    int n_fail = 0;
    int compares = 0;

    always #25 sys_clk = ~sys_clk;

    flash_master_model u_master (.serial_clock(serial_clock), .chip_select_low(chip_select_low),
        .serial_data_in(serial_data_in), .data_out(data_out));

    serial_flash_cmds #(.WRITE_CYCLES(20), .SILICON_ID(SID)) DUT (
        .sys_clk(sys_clk), .rst(rst), .serial_clock(serial_clock),
        .chip_select_low(chip_select_low), .serial_data_in(serial_data_in),
        .raw_lsb_first(raw_lsb_first), .mem_we(mem_we), .mem_waddr(mem_waddr),
        .mem_wdata(mem_wdata), .prog_addr(prog_addr), .prog_req(prog_req),
        .prog_refused(prog_refused), .data_out(data_out), .data_out_en(data_out_en),
        .write_in_progress(write_in_progress), .block_protect(block_protect));

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // frame, then select stays high long enough for the sys_clk side
    task automatic frame(input logic [47:0] tx, input int ntx, input int nrx);
        u_master.xfer(tx, ntx, nrx, rx);
        repeat (6) @(posedge sys_clk);
    endtask

    task automatic watch_busy(input int n);
        seen = 1'b0;
        repeat (n) @(posedge sys_clk) if (write_in_progress === 1'b1) seen = 1'b1;
    endtask

    task automatic load(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        mem_waddr <= a;
        mem_wdata <= d;
        mem_we <= 1'b1;
        @(posedge sys_clk);
        mem_we <= 1'b0;
    endtask

    task automatic t_reads();
        load(8'hFF, 8'h1E);
        load(8'h00, 8'hB4);
        frame({OP_READ_BYTES, 24'hAB_00FF, 16'h0000}, 32, 16);
        check(rx, 16'h1EB4, "read bytes wrap");
        frame({OP_FAST_READ, 24'h00_00FF, 16'h0000}, 40, 16);
        check(rx, 16'h1EB4, "fast read wrap");
        @(posedge sys_clk) raw_lsb_first <= 1'b1;
        frame({OP_FAST_READ, 24'h00_00FF, 16'h0000}, 40, 16);
        check(rx, 16'h782D, "raw lsb first");
        @(posedge sys_clk) raw_lsb_first <= 1'b0;
        frame({OP_READ_SILICON_ID, 24'h00_0000, 16'h0000}, 32, 16);
        check(rx, {SID, SID}, "silicon id repeat");
    endtask

    task automatic t_status();
        frame({OP_WRITE_STATUS, 8'h1C, 32'h0000_0000}, 16, 0);
        watch_busy(40);
        check({15'h0000, seen}, 16'h0000, "status write without latch");
        frame({OP_WRITE_ENABLE, 40'h00_0000_0000}, 8, 0);
        // a frame one bit past the byte boundary must be rejected whole
        frame({OP_WRITE_STATUS, 8'h1C, 32'h0000_0000}, 17, 0);
        watch_busy(40);
        check({15'h0000, seen}, 16'h0000, "misframed status write");
        frame({OP_WRITE_ENABLE, 40'h00_0000_0000}, 8, 0);
        frame({OP_WRITE_STATUS, 8'h1C, 32'h0000_0000}, 16, 0);
        check({15'h0000, write_in_progress}, 16'h0001, "busy after status write");
        frame({OP_READ_BYTES, 24'h00_00FF, 16'h0000}, 32, 16);
        check({13'h0000, block_protect}, 16'h0000, "protect held while busy");
        check({15'h0000, write_in_progress}, 16'h0001, "read left busy alone");
        watch_busy(0);
        for (int i = 0; i < 40 && write_in_progress !== 1'b0; i++) @(posedge sys_clk);
        check({15'h0000, write_in_progress}, 16'h0000, "busy cleared");
        check({13'h0000, block_protect}, 16'h0007, "protect bits written");
        // latch cleared on completion, so a second write must not run
        frame({OP_WRITE_STATUS, 8'h00, 32'h0000_0000}, 16, 0);
        watch_busy(40);
        check({15'h0000, seen}, 16'h0000, "latch cleared at completion");
        check({13'h0000, block_protect}, 16'h0007, "protect bits kept");
    endtask

    task automatic t_protect();
        @(posedge sys_clk);
        prog_addr <= 8'h10;
        prog_req <= 1'b1;
        @(posedge sys_clk);
        prog_req <= 1'b0;
        seen = 1'b0;
        repeat (3) @(posedge sys_clk) if (prog_refused === 1'b1) seen = 1'b1;
        check({15'h0000, seen}, 16'h0001, "program into protected area");
        load(8'h00, 8'h55);
        frame({OP_READ_BYTES, 24'h00_0000, 16'h0000}, 32, 8);
        check(rx, 16'h00B4, "write into protected area");
    endtask

    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        t_reads();
        t_status();
        t_protect();
        stop_test();
    end

    // whole run is a few hundred sys_clk cycles
    initial begin
        #1_000_000;
        n_fail++;
        stop_test();
    end
endmodule // tb_serial_flash_read_and_status_cmds
